//--- logic/array_bit_broadcast_and_scalar_add.sv
`timescale 1ns/1ps
// How it works
// [RL1] Broadcast selected register bit into every activity bit
// [RL2] Inverted variant loads complement of that bit
// [RL3] Source from select field; plane address ignored
// [RL4] Bit position: int plus modifier plus loop step
// [RL5] Wrap modulo width, or edge size for edge
// [RL6] Register add writes sum to select register
// [RL7] Add-with-carry uses carry flag as carry-in
// [RL8] Literal add into select register, no carry
// [RL9] Literal zero-extended to 32 bits
// [RL10] Literal add with carry adds carry flag
// [RL11] All four adds update carry and overflow
// [RL12] Low-word carry chains into high-word add
// [RL13] Compound ops act as two ops in order; op 8 does not load the row and column planes
// [RL14] Row broadcast: register at row low end, zeros
// [RL15] Column broadcast: register at column low end
// [RL17] Plane operations identical in every element
// [RL18] Carry is bit-31 carry; overflow is signed
// [RL19] These instructions never raise an error
module array_bit_broadcast_and_scalar_add
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [scalar_array_pkg::EDGE_W-1:0] loop_count, // Loop iteration
  input wire logic in_loop, // Inside a do-loop
  output logic [scalar_array_pkg::PE_N-1:0] activity_plane, // Activity bits
  output logic [scalar_array_pkg::EDGE_SIZE-1:0] row_plane, // Row broadcast
  output logic [scalar_array_pkg::EDGE_SIZE-1:0] col_plane, // Col broadcast
  output logic irq // Level interrupt
);
  import scalar_array_pkg::*;

  logic [REG_W-1:0] regs_q [NREG];
  logic [EDGE_SIZE-1:0] edge_q;
  logic carry_q;
  logic overflow_flag_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [PE_N-1:0] act_q;
  logic [EDGE_SIZE-1:0] row_q;
  logic [EDGE_SIZE-1:0] col_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  logic acc;
  logic wr;
  logic rd;
  logic cmd_go;
  instr_t ins;
  logic [REG_W-1:0] wmask;

  assign acc = psel && penable && !pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cmd_go = wr && (paddr == OFS_CMD);
  assign ins = instr_t'(pwdata);

  function automatic logic is_reg_addr(input logic [11:0] a);
    is_reg_addr = (a >= OFS_REG0) && (a < OFS_REGEND) && (a[1:0] == 2'h0);
  endfunction : is_reg_addr

  function automatic logic [SEL_W-1:0] reg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFS_REG0;
    reg_idx = d[SEL_W+1:2];
  endfunction : reg_idx

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == OFS_CMD) || (a == OFS_FLAGS) ||
      (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_ACTSUM) ||
      (a == OFS_EDGE) || is_reg_addr(a);
  endfunction : known_addr

  function automatic add_res_t add32(input logic [REG_W-1:0] a,
                                     input logic [REG_W-1:0] b,
                                     input logic cin);
    logic [REG_W:0] s;
    s = {1'b0, a} + {1'b0, b} + {{REG_W{1'b0}}, cin};
    add32.sum = s[REG_W-1:0];
    add32.carry = s[REG_W]; // [RL18]
    add32.overflow_flag = (a[REG_W-1] == b[REG_W-1]) &&
      (s[REG_W-1] != a[REG_W-1]); // [RL18]
  endfunction : add32

  // Strobe-aware write mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Effective bit position
  logic [15:0] mod_int;
  logic [15:0] step_amt;
  logic [15:0] raw_pos;
  logic [EDGE_W-1:0] bit_pos;
  logic src_bit;
  logic [REG_W-1:0] src_word;
  logic fwd;
  logic [REG_W-1:0] mod_word;
  // Sum is shared by the register write and the forwarding
  add_res_t res;

  always_comb
  begin
    // Op 8 reads what its own add leaves behind
    fwd = (ins.op == OP_ADD_BCAST);
    mod_word = (fwd && ins.mod_sel == ins.reg_sel) ? res.sum
      : regs_q[ins.mod_sel]; // [RL13]
    mod_int = (ins.mod_sel == NO_MOD) ? 16'h0000
      : mod_word[15:0]; // [RL4]
    step_amt = {{(16-EDGE_W){1'b0}}, loop_count};
    raw_pos = ins.int_field + mod_int; // [RL4]
    if (in_loop && ins.step == STEP_UP)
    begin
      raw_pos = raw_pos + step_amt; // [RL4]
    end
    else if (in_loop && ins.step == STEP_DOWN)
    begin
      raw_pos = raw_pos - step_amt; // [RL4]
    end
    // Both widths are powers of two, so wrap is a truncation;
    // a non-power-of-two edge size would need a real modulo
    if (ins.reg_sel == EDGE_SEL)
    begin
      bit_pos = raw_pos[EDGE_W-1:0]; // [RL5]
      src_word = REG_W'(edge_q);
    end
    else
    begin
      bit_pos = raw_pos[BIT_W-1:0]; // [RL5]
      src_word = fwd ? res.sum : regs_q[ins.reg_sel]; // [RL3] [RL13]
    end
    src_bit = src_word[bit_pos]; // [RL1] [RL3]
  end

  // Scalar add datapath
  logic [REG_W-1:0] opb;
  logic cin;
  logic is_add;

  always_comb
  begin
    opb = regs_q[ins.mod_sel]; // [RL6]
    cin = 1'b0;
    is_add = 1'b1;
    case (ins.op)
      OP_ADD: cin = 1'b0;
      OP_ADD_BCAST: cin = 1'b0;
      OP_SCALAR_REG_ADD_CARRY: cin = carry_q; // [RL7] [RL12]
      OP_SCALAR_LITERAL_ADD:
      begin
        opb = {{(REG_W-LIT_W){1'b0}}, ins.int_field}; // [RL8] [RL9]
        cin = 1'b0; // [RL8]
      end
      OP_SCALAR_LITERAL_ADD_CARRY:
      begin
        opb = {{(REG_W-LIT_W){1'b0}}, ins.int_field}; // [RL9] [RL10]
        cin = carry_q; // [RL10]
      end
      default: is_add = 1'b0;
    endcase
    res = add32(regs_q[ins.reg_sel], opb, cin);
  end

  // Register file and edge register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs_q[i] <= REG_RST;
      end
      edge_q <= '0;
    end
    else if (cmd_go && is_add)
    begin
      regs_q[ins.reg_sel] <= res.sum; // [RL6] [RL8] [RL10]
    end
    else if (wr && is_reg_addr(paddr))
    begin
      regs_q[reg_idx(paddr)] <= (regs_q[reg_idx(paddr)] & ~wmask) |
        (pwdata & wmask);
    end
    else if (wr && paddr == OFS_EDGE)
    begin
      edge_q <= (edge_q & ~wmask[EDGE_SIZE-1:0]) |
        (pwdata[EDGE_SIZE-1:0] & wmask[EDGE_SIZE-1:0]);
    end
  end

  // Flags
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carry_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end
    else if (cmd_go && is_add)
    begin
      carry_q <= res.carry; // [RL11] [RL12]
      overflow_flag_q <= res.overflow_flag; // [RL11]
    end
    else if (wr && paddr == OFS_FLAGS && pstrb[0])
    begin
      carry_q <= pwdata[0];
      overflow_flag_q <= pwdata[1];
    end
  end

  // Activity plane, every element loaded alike
  logic [PE_N-1:0] act_d;

  always_comb
  begin
    act_d = act_q;
    case (ins.op)
      OP_BCAST: act_d = {PE_N{src_bit}}; // [RL1] [RL17]
      OP_BCAST_INV: act_d = {PE_N{~src_bit}}; // [RL2] [RL17]
      OP_CLR_A: act_d = '0; // [RL17]
      // Add then broadcast: the source word, and the modifier word when
      // mod_sel names the added register, are forwarded from the sum, so
      // the broadcast sees the registers as the add leaves them
      OP_ADD_BCAST: act_d = {PE_N{src_bit}}; // [RL13]
      default: act_d = act_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q <= '0;
    end
    else if (cmd_go)
    begin
      act_q <= act_d;
    end
  end

  // Row and column broadcast planes: contents at low end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_q <= '0;
      col_q <= '0;
    end
    else if (cmd_go && (ins.op == OP_BCAST || ins.op == OP_BCAST_INV))
    begin
      row_q <= src_word[EDGE_SIZE-1:0]; // [RL14]
      col_q <= src_word[EDGE_SIZE-1:0]; // [RL15]
    end
  end

  // Sticky status, write one to clear, set wins
  logic [ST_W-1:0] ev;

  always_comb
  begin
    ev = '0;
    ev[ST_DONE] = cmd_go;
    ev[ST_CARRY] = cmd_go && is_add && res.carry;
    ev[ST_OVERFLOW_FLAG] = cmd_go && is_add && res.overflow_flag;
    // Unknown opcodes are flagged, never trapped
    ev[ST_BADOP] = cmd_go && (ins.op > OP_ADD_BCAST); // [RL19]
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      if (wr && paddr == OFS_STATUS && pstrb[0])
      begin
        status_q <= (status_q & ~pwdata[ST_W-1:0]) | ev;
      end
      else
      begin
        status_q <= status_q | ev;
      end
      if (wr && paddr == OFS_MASK && pstrb[0])
      begin
        mask_q <= pwdata[ST_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // APB answer: one wait state, pready pulses for one cycle
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (is_reg_addr(paddr))
    begin
      rdata = regs_q[reg_idx(paddr)];
    end
    else
    begin
      case (paddr)
        OFS_FLAGS: rdata = {30'h0000_0000, overflow_flag_q, carry_q};
        OFS_STATUS: rdata = {28'h000_0000, status_q};
        OFS_MASK: rdata = {28'h000_0000, mask_q};
        OFS_ACTSUM: rdata = {31'h0000_0000, act_q[0]};
        OFS_EDGE: rdata = edge_q;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !known_addr(paddr);
      if (rd)
      begin
        prdata_q <= rdata;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign activity_plane = act_q;
  assign row_plane = row_q;
  assign col_plane = col_q;

endmodule : array_bit_broadcast_and_scalar_add

//--- logic/scalar_array_pkg.sv
package scalar_array_pkg;

  localparam int REG_W = 32;
  localparam int NREG = 16;
  localparam int SEL_W = 4;
  localparam int LIT_W = 16;
  localparam int BIT_W = 5;
  localparam int EDGE_SIZE = 32;
  localparam int EDGE_W = 5;
  localparam int PE_N = EDGE_SIZE * EDGE_SIZE;
  localparam logic [SEL_W-1:0] EDGE_SEL = 4'hF;
  localparam logic [SEL_W-1:0] NO_MOD = 4'h0;
  localparam logic [REG_W-1:0] REG_RST = 32'h0000_0000;

  // Register bus map, byte addresses
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_FLAGS = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_MASK = 12'h00C;
  localparam logic [11:0] OFS_ACTSUM = 12'h010;
  localparam logic [11:0] OFS_EDGE = 12'h014;
  localparam logic [11:0] OFS_REG0 = 12'h040;
  localparam logic [11:0] OFS_REGEND = 12'h080;

  // Command word fields
  localparam int F_OP = 0;
  localparam int F_SEL = 4;
  localparam int F_MOD = 8;
  localparam int F_STEPM = 12;
  localparam int F_INT = 16;
  localparam int F_LIT = 16;

  // Status bits
  localparam int ST_DONE = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_OVERFLOW_FLAG = 2;
  localparam int ST_BADOP = 3;
  localparam int ST_W = 4;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_BCAST = 4'h1,
    OP_BCAST_INV = 4'h2,
    OP_ADD = 4'h3,
    OP_SCALAR_REG_ADD_CARRY = 4'h4,
    OP_SCALAR_LITERAL_ADD = 4'h5,
    OP_SCALAR_LITERAL_ADD_CARRY = 4'h6,
    OP_CLR_A = 4'h7,
    OP_ADD_BCAST = 4'h8
  } opcode_t;

  typedef enum logic [1:0] {
    STEP_NONE = 2'h0,
    STEP_UP = 2'h1,
    STEP_DOWN = 2'h2
  } step_t;

  typedef struct packed {
    logic [15:0] int_field;
    logic [1:0] spare;
    step_t step;
    logic [SEL_W-1:0] mod_sel;
    logic [SEL_W-1:0] reg_sel;
    opcode_t op;
  } instr_t;

  typedef struct packed {
    logic [REG_W-1:0] sum;
    logic carry;
    logic overflow_flag;
  } add_res_t;

endpackage : scalar_array_pkg

//--- tb/bcast_add_props.sv
`timescale 1ns/1ps
module bcast_add_props
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [scalar_array_pkg::PE_N-1:0] activity_plane, // Activity
  input wire logic [scalar_array_pkg::EDGE_SIZE-1:0] row_plane, // Row
  input wire logic [scalar_array_pkg::EDGE_SIZE-1:0] col_plane // Column
);
  import scalar_array_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = psel && penable && !pready;
  wire logic cmd = psel && pwrite && paddr == OFS_CMD;
  a_ready_pulse: assert property (acc |=> pready ##1 !pready)
    else $error("ready late or long");
  a_no_stray: assert property (pready |-> $past(acc))
    else $error("ready without access");
  a_cmd_no_err: assert property (acc && cmd |=> !pslverr)
    else $error("command refused");
  a_hole_err: assert property (acc && paddr inside {[12'h018:12'h03C]}
    |=> pslverr) else $error("hole accepted");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0000_0000) else $error("hole read data");
  a_plane_same: assert property (
    activity_plane == {PE_N{activity_plane[0]}}) else $error("plane split");
  a_row_col: assert property (row_plane == col_plane)
    else $error("row and column differ");
  a_act_cause: assert property (!$stable(activity_plane) |->
    $past(cmd) || $past(cmd, 2) || $past(cmd, 3))
    else $error("activity moved alone");
  cover property (pready && pslverr);
  cover property ($rose(activity_plane[0]));
  cover property (acc && cmd);
endmodule : bcast_add_props

bind array_bit_broadcast_and_scalar_add bcast_add_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .activity_plane(activity_plane),
  .row_plane(row_plane), .col_plane(col_plane));

//--- tb/loop_issuer.sv
`timescale 1ns/1ps
module loop_issuer
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic go, // Enter loop
  input wire logic [scalar_array_pkg::EDGE_W-1:0] iter, // Iteration
  output logic in_loop, // Inside loop
  output logic [scalar_array_pkg::EDGE_W-1:0] loop_count // Iteration no.
);
  import scalar_array_pkg::*;
  // Count held while the loop body issues
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      in_loop <= 1'b0;
      loop_count <= '0;
    end
    else
    begin
      in_loop <= go;
      loop_count <= go ? iter : ~iter;
    end
endmodule : loop_issuer

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import scalar_array_pkg::*;
  typedef struct {opcode_t op; logic [31:0] a, b; logic ci;
    logic [15:0] im;} row_t;
  logic sys_clk, rst_n, psel, penable, pwrite, go, pready, pslverr;
  logic irq, e, in_loop, msk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [EDGE_W-1:0] iter, loop_count;
  logic [PE_N-1:0] activity_plane;
  logic [EDGE_SIZE-1:0] row_plane, col_plane;
  logic [33:0] x;
  int num_errors, comparisons, cycles;
  row_t rows[9];
  array_bit_broadcast_and_scalar_add dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_count(loop_count),
    .in_loop(in_loop), .activity_plane(activity_plane),
    .row_plane(row_plane), .col_plane(col_plane), .irq(irq));
  loop_issuer issuer (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .iter(iter), .in_loop(in_loop), .loop_count(loop_count));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] w);
    comparisons++;
    if (g !== w)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, w);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task exec(input opcode_t op, input logic [3:0] s, input logic [3:0] m,
    input step_t st, input logic [15:0] im);
    instr_t c;
    c = '{im, 2'h0, st, m, s, op};
    apb(1'b1, OFS_CMD, c);
    r = '0;
    for (int i = 0; i < 10 && r[ST_DONE] !== 1'b1; i++)
      apb(1'b0, OFS_STATUS, 32'h0);
    chk(r & 32'h0000_0009, 32'h0000_0001);
    chk(32'(irq), 32'(msk));
    apb(1'b1, OFS_STATUS, 32'h0000_000F);
  endtask : exec
  function automatic logic [31:0] bexp(row_t w);
    logic [4:0] p;
    p = 5'(w.im + w.b[15:0]);
    return 32'(w.a[p] ^ (w.op == OP_BCAST_INV));
  endfunction : bexp
  function automatic logic [33:0] aexp(row_t w);
    logic [31:0] bb;
    logic [32:0] t;
    bb = w.op inside {OP_SCALAR_LITERAL_ADD, OP_SCALAR_LITERAL_ADD_CARRY} ? {16'h0000, w.im} : w.b;
    t = {1'b0, w.a} + {1'b0, bb};
    t = t + (w.op inside {OP_SCALAR_REG_ADD_CARRY, OP_SCALAR_LITERAL_ADD_CARRY} ? 33'(w.ci) : 33'h0);
    return {w.a[31] == bb[31] && t[31] != w.a[31], t};
  endfunction : aexp
  initial
  begin
    {rst_n, psel, penable, pwrite, go, msk} = '0;
    {paddr, pwdata, iter, num_errors, comparisons, cycles} = '0;
    rows = '{'{OP_ADD, 32'hFFFF_FFFF, 32'h1, 1'b1, 16'h0},
      '{OP_ADD, 32'h7FFF_FFFF, 32'h1, 1'b0, 16'h0},
      '{OP_SCALAR_REG_ADD_CARRY, 32'h1, 32'h1, 1'b1, 16'h0},
      '{OP_SCALAR_REG_ADD_CARRY, 32'h8000_0000, 32'h8000_0000, 1'b0, 16'h0},
      '{OP_SCALAR_LITERAL_ADD, 32'hFFFF_0001, 32'h0, 1'b1, 16'hFFFF},
      '{OP_SCALAR_LITERAL_ADD_CARRY, 32'h7FFF_7FFF, 32'h0, 1'b1, 16'h8000},
      '{OP_BCAST, 32'h0000_0400, 32'h3, 1'b0, 16'h0007},
      '{OP_BCAST_INV, 32'h0000_0400, 32'h0001_001E, 1'b0, 16'h000C},
      '{OP_BCAST, 32'h8000_0000, 32'h0, 1'b0, 16'h001F}};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_REG0 + 12'h014, 32'h0);
    chk(r, REG_RST);
    foreach (rows[i])
    begin
      apb(1'b1, OFS_FLAGS, 32'(rows[i].ci));
      apb(1'b1, OFS_REG0 + 12'h004, rows[i].a);
      apb(1'b1, OFS_REG0 + 12'h008, rows[i].b);
      exec(rows[i].op, 4'h1, 4'h2, STEP_NONE, rows[i].im);
      x = aexp(rows[i]);
      apb(1'b0, OFS_REG0 + 12'h004, 32'h0);
      if (rows[i].op inside {OP_BCAST, OP_BCAST_INV})
      begin
        chk(32'(activity_plane[0]), bexp(rows[i]));
        chk(row_plane, rows[i].a);
        chk(col_plane, rows[i].a);
      end
      else
        chk(r, x[31:0]);
      apb(1'b0, OFS_FLAGS, 32'h0);
      if (!(rows[i].op inside {OP_BCAST, OP_BCAST_INV}))
        chk(r & 32'h3, 32'(x[33:32]));
    end
    apb(1'b1, OFS_REG0 + 12'h004, 32'hFFFF_FFFF);
    apb(1'b1, OFS_REG0 + 12'h008, 32'h1);
    apb(1'b1, OFS_REG0 + 12'h00C, 32'h5);
    apb(1'b1, OFS_REG0 + 12'h010, 32'h10);
    exec(OP_ADD, 4'h1, 4'h2, STEP_NONE, 16'h0);
    exec(OP_SCALAR_REG_ADD_CARRY, 4'h3, 4'h4, STEP_NONE, 16'h0);
    apb(1'b0, OFS_REG0 + 12'h00C, 32'h0);
    chk(r, 32'h0000_0016);
    apb(1'b1, OFS_EDGE, 32'h2000_0000);
    go <= 1'b1;
    iter <= 5'h05;
    exec(OP_BCAST, EDGE_SEL, NO_MOD, STEP_DOWN, 16'h0002);
    chk(32'(activity_plane[0]), 32'h1);
    chk(col_plane, 32'h2000_0000);
    exec(OP_BCAST_INV, EDGE_SEL, NO_MOD, STEP_UP, 16'h0018);
    chk(32'(activity_plane[0]), 32'h0);
    go <= 1'b0;
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, OFS_REG0 + 12'h014, 32'h0);
    apb(1'b1, OFS_REG0 + 12'h018, 32'h0000_0100);
    exec(OP_ADD_BCAST, 4'h5, 4'h6, STEP_NONE, 16'h0008);
    chk(32'(activity_plane[0]), 32'h1);
    apb(1'b0, OFS_REG0 + 12'h014, 32'h0);
    chk(r, 32'h0000_0100);
    apb(1'b1, OFS_CMD, 32'h0000_0009);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r, 32'h0000_0009);
    chk(32'(activity_plane[0]), 32'h1);
    apb(1'b1, OFS_STATUS, 32'h0000_000F);
    exec(OP_CLR_A, 4'h0, 4'h0, STEP_NONE, 16'h0);
    chk(32'(activity_plane[0]), 32'h0);
    msk = 1'b1;
    apb(1'b1, OFS_MASK, 32'h1);
    exec(OP_NOP, 4'h0, 4'h0, STEP_NONE, 16'h0);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFS_REG0 + 12'h004, 32'h0000_00FF);
    exec(OP_BCAST, 4'h1, NO_MOD, STEP_NONE, 16'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'(activity_plane[0]), 32'h0);
    chk(row_plane, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, OFS_REG0 + 12'h004, 32'h0);
    chk(r, REG_RST);
    tally_and_finish();
  end
endmodule : tb_top
